// *** sim/ccr_mem_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccr_mem_model (
    input wire logic ref_clk,
    input wire logic [15:0] mem_addr,
    input wire logic code_re,
    input wire logic xram_re,
    input wire logic xram_we,
    input wire logic [7:0] xram_wdata,
    output logic [7:0] code_rdata,
    output logic [7:0] xram_rdata
);
    logic [7:0] xmem [256];
    // Idle cycles flip the read bus so that a stale byte never passes for an answer.
    always @(posedge ref_clk)
    begin
        code_rdata <= code_re ? (mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3c) : ~code_rdata;
        xram_rdata <= xram_re ? xmem[mem_addr[7:0]] : ~xram_rdata;
        if (xram_we)
            xmem[mem_addr[7:0]] <= xram_wdata;
    end
endmodule
`default_nettype wire

// *** sim/cpu_core_registers_addressing_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module cpu_core_registers_addressing_bench;
    import ccr_pkg::*;
    logic ref_clk = 0;
    logic srst = 1;
    logic [3:0] sfr_page = 4'h0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 0;
    logic sfr_rd = 0;
    logic rdf = 0;
    logic instr_start = 0;
    logic [2:0] instr_cycles = 3'h0;
    logic [7:0] sfr_rdata, opnd_rdata, code_rdata, xram_rdata, xram_wdata, v;
    logic sfr_hit, opnd_busy, opnd_done, opnd_fault, code_re, xram_re, xram_we, instr_done;
    logic [15:0] mem_addr, prog_cnt, t;
    ccr_opnd_req_t oreq = '0;
    ccr_alu_req_t areq = '0;
    ccr_flow_req_t freq = '0;
    ccr_regs_t arch;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;
    logic [8:0] sq[$];
    logic [9:0] oq[$];
    logic [9:0] oe;
    ccr_core dut (.ref_clk(ref_clk), .srst(srst), .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_reg(sfr_rdata), .sfr_hit_reg(sfr_hit), .opnd_req(oreq),
        .opnd_busy_reg(opnd_busy), .opnd_done_reg(opnd_done), .opnd_fault_reg(opnd_fault), .opnd_rdata_reg(opnd_rdata),
        .mem_addr_reg(mem_addr), .code_re_reg(code_re), .xram_re_reg(xram_re), .xram_we_reg(xram_we),
        .xram_wdata_reg(xram_wdata), .code_rdata(code_rdata), .xram_rdata(xram_rdata), .alu_req(areq),
        .flow_req(freq), .instr_start(instr_start), .instr_cycles(instr_cycles), .instr_done_reg(instr_done),
        .arch_reg(arch), .program_counter_reg(prog_cnt));
    ccr_mem_model mem (.ref_clk(ref_clk), .mem_addr(mem_addr), .code_re(code_re), .xram_re(xram_re),
        .xram_we(xram_we), .xram_wdata(xram_wdata), .code_rdata(code_rdata), .xram_rdata(xram_rdata));
    always #20 ref_clk = ~ref_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (err_total == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [8:0] e);
        sfr_wr = w;
        sfr_rd = !w;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_page = 4'($urandom);
        if (!w)
            sq.push_back(e);
        @(negedge ref_clk);
        sfr_wr = 0;
        sfr_rd = 0;
        @(negedge ref_clk);
    endtask
    task automatic opnd(input logic w, input ccr_mode_t m, input logic [7:0] f, input logic [7:0] d,
        input logic [9:0] e);
        oreq = '{1'b1, w, 1'b0, m, f, d};
        oq.push_back(e);
        @(negedge ref_clk);
        oreq.valid = 0;
        chk(16'(opnd_busy), 16'h0001);
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic alu(input ccr_alu_op_t o, input logic [7:0] d, input logic b);
        areq = '{o, d, b};
        @(negedge ref_clk);
    endtask
    always @(posedge ref_clk)
    begin
        rdf <= sfr_rd;
        cyc <= cyc + 1;
        if (cyc > 3000)
        begin
            err_total++;
            end_sim();
        end
    end
    always @(negedge ref_clk)
    begin
        if (rdf === 1'b1)
            chk(16'({sfr_hit, sfr_rdata}), 16'(sq.pop_front()));
        if (opnd_done === 1'b1)
        begin
            oe = oq.pop_front();
            chk(16'({opnd_fault, oe[9] ? opnd_rdata : oe[7:0]}), 16'(oe[8:0]));
        end
    end
    initial
    begin
        n = $urandom(51200);
        repeat (16) @(negedge ref_clk);
        srst = 0;
        chk(16'(arch.stack_pointer), 16'(RST_STACK));
        chk({arch.data_pointer_high, arch.data_pointer_low}, 16'h0000);
        chk({arch.program_status_word, arch.second_operand_reg}, 16'h0000);
        chk(prog_cnt, 16'h0000);
        sfr(1'b0, ADDR_STACK, 8'h00, {1'b1, RST_STACK});
        sfr(1'b0, 8'h85, 8'h00, 9'h000);
        repeat (4)
        begin
            v = 8'($urandom);
            sfr(1'b1, ADDR_ARITH, v, 9'h000);
            sfr(1'b0, ADDR_ARITH, 8'h00, {1'b1, v});
            chk(16'(arch.program_status_word[BIT_PARITY]), 16'(^v));
        end
        sfr(1'b1, ADDR_DP_LOW, 8'h10, 9'h000);
        sfr(1'b1, ADDR_DP_HIGH, 8'h00, 9'h000);
        chk({arch.data_pointer_high, arch.data_pointer_low}, 16'h0010);
        opnd(1'b1, MODE_IND16, 8'h00, 8'ha5, 10'h000);
        opnd(1'b0, MODE_IND16, 8'h00, 8'h00, 10'h2a5);
        t = 16'h0010 + 16'(v);
        opnd(1'b0, MODE_IDX_DATA, 8'h00, 8'h00, {2'b10, t[7:0] ^ t[15:8] ^ 8'h3c});
        opnd(1'b1, MODE_IDX_DATA, 8'h00, 8'h11, 10'h100);
        alu(ALU_PUSH, 8'h5a, 1'b0);
        areq = '0;
        chk(16'(arch.stack_pointer), 16'(RST_STACK + 8'h01));
        opnd(1'b0, MODE_IND8, 8'h02, 8'h00, 10'h25a);
        sfr(1'b1, ADDR_STATUS, 8'h10, 9'h000);
        opnd(1'b1, MODE_REG, 8'h03, 8'hc3, 10'h000);
        opnd(1'b0, MODE_DIR, 8'h13, 8'h00, 10'h2c3);
        freq = '{1'b0, 2'h0, 1'b1, 5'h01, 1'b0};
        @(negedge ref_clk);
        freq = '{1'b1, 2'h0, 1'b0, 5'h00, 1'b1};
        chk(prog_cnt, 16'h000b);
        @(negedge ref_clk);
        freq = '0;
        chk(prog_cnt, 16'h0010 + 16'(v));
        alu(ALU_POP, 8'h00, 1'b0);
        areq = '0;
        chk({arch.stack_pointer, arch.main_arith_register}, {RST_STACK, 8'h5a});
        sfr(1'b1, ADDR_SECOND, 8'h03, 9'h000);
        alu(ALU_MUL, 8'h00, 1'b0);
        chk({arch.second_operand_reg, arch.main_arith_register}, 16'h010e);
        n = $urandom;
        alu(ALU_SET_CARRY, 8'h00, 1'b0);
        alu(ALU_AND_CARRY, 8'h00, n[0]);
        chk(16'(arch.program_status_word[BIT_CARRY]), 16'(n[0]));
        alu(ALU_ADD, 8'hf2, 1'b0);
        areq = '0;
        chk(16'(arch.program_status_word), 16'h00d0);
        opnd(1'b0, MODE_DIR, ADDR_STATUS, 8'h00, 10'h2d0);
        opnd(1'b0, MODE_IDX_PROG, 8'h00, 8'h00, {2'b10, t[7:0] ^ t[15:8] ^ 8'h3c});
        instr_cycles = 3'h7;
        instr_start = 1;
        @(negedge ref_clk);
        instr_start = 0;
        n = 1;
        while (instr_done !== 1'b1 && n < 20)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk(16'(n), 16'h0007);
        end_sim();
    end
endmodule
`default_nettype wire

// *** src/ccr_core.sv ***
// Behaviour
// - Status word bits are carry, half carry, flag0, bank high/low, wrap, flag1, parity.
// - The six core registers answer at their address on every page 0 to F.
// - Two bank bits choose one of four banks of eight working registers.
// - Parity bit always equals odd count of ones in the main register.
// - Carry is the one-bit accumulator for Boolean bit operations.
// - Stack pointer increments before the pushed byte is written.
// - Reset gives stack pointer 07 and zero in the other core registers.
// - Wide data pointer is high byte over low byte, addressing XRAM and flash.
// - Second operand register joins the main register in multiply and divide.
// - Instructions last 1 to 7 clock cycles, counted in plain clocks.
// - Direct mode uses an 8-bit field reaching internal RAM and special registers only.
// - 8-bit indirect uses working register 0, 1 or the stack pointer.
// - 16-bit indirect uses only the wide data pointer.
// - Register form picks one of eight working registers of the current bank.
// - Immediate operands are read from program bytes after the opcode.
// - Indexed mode is read-only program memory, base plus main register.
// - Indexed jump target is base pointer plus main register.
// - Program memory is on-chip and never written by the core.
// - After reset fetching starts at address 0000.
// - Interrupt vectors start at 0003 and are spaced 8 bytes apart.
// - Data space is separate and holds 256 bytes of scratch-pad RAM.
// - Above 7F, direct reaches special registers, indirect reaches upper RAM.
// - Working-register banks fill the lowest 32 bytes of internal RAM.
`timescale 1ns/10ps
`default_nettype none
module ccr_core
    import ccr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [3:0] sfr_page,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata_reg,
    output logic sfr_hit_reg,
    input wire ccr_opnd_req_t opnd_req,
    output logic opnd_busy_reg,
    output logic opnd_done_reg,
    output logic opnd_fault_reg,
    output logic [7:0] opnd_rdata_reg,
    output logic [15:0] mem_addr_reg,
    output logic code_re_reg,
    output logic xram_re_reg,
    output logic xram_we_reg,
    output logic [7:0] xram_wdata_reg,
    input wire logic [7:0] code_rdata,
    input wire logic [7:0] xram_rdata,
    input wire ccr_alu_req_t alu_req,
    input wire ccr_flow_req_t flow_req,
    input wire logic instr_start,
    input wire logic [2:0] instr_cycles,
    output logic instr_done_reg,
    output var ccr_regs_t arch_reg,
    output logic [15:0] program_counter_reg
);
    logic [7:0] iram_reg [256];
    ccr_regs_t arch_next;
    ccr_op_state_t state_reg;
    ccr_space_t space_reg;
    logic write_reg;
    logic fault_reg;
    logic [7:0] hold_reg;
    logic [2:0] cnt_reg;
    ccr_space_t res_space;
    logic [15:0] res_addr;

    ////////////////////////////////////////////////////////////////////////////
    // The page number is deliberately not decoded: these six registers are
    // mirrored on every page so code never has to switch pages to reach them.
    function automatic logic [8:0] sfr_lookup(input logic [7:0] a, input ccr_regs_t r);
        logic [8:0] v;
        v = {1'b0, RST_ZERO};
        case (a)
            ADDR_STACK: v = {1'b1, r.stack_pointer};
            ADDR_DP_LOW: v = {1'b1, r.data_pointer_low};
            ADDR_DP_HIGH: v = {1'b1, r.data_pointer_high};
            ADDR_STATUS: v = {1'b1, r.program_status_word};
            ADDR_ARITH: v = {1'b1, r.main_arith_register};
            ADDR_SECOND: v = {1'b1, r.second_operand_reg};
            default: v = {1'b0, RST_ZERO};
        endcase
        return v;
    endfunction

    wire [7:0] status = arch_reg.program_status_word;
    wire [7:0] arith = arch_reg.main_arith_register;
    wire [7:0] second = arch_reg.second_operand_reg;
    wire [7:0] stk = arch_reg.stack_pointer;
    wire [15:0] arith16 = {8'h00, arith};
    wire [15:0] wide_data_pointer = {arch_reg.data_pointer_high, arch_reg.data_pointer_low};
    wire [1:0] bank = status[BIT_BSH:BIT_BSL];
    wire [7:0] bank_base = {3'h0, bank, 3'h0};
    wire [7:0] ind_reg_addr = bank_base | {7'h00, opnd_req.field[0]};
    wire [7:0] ind_ptr = opnd_req.field[1] ? stk : iram_reg[ind_reg_addr];
    wire [7:0] work_addr = bank_base | {5'h00, opnd_req.field[2:0]};
    wire take = opnd_req.valid && state_reg == OP_IDLE;
    wire res_fault = opnd_req.write && res_space == SPACE_CODE;

    always_comb
    begin
        res_space = SPACE_IRAM;
        res_addr = {8'h00, opnd_req.field};
        case (opnd_req.mode)
            MODE_DIR: res_space = opnd_req.field > DIRECT_TOP ? SPACE_SFR : SPACE_IRAM;
            MODE_IND8:
            begin
                res_space = opnd_req.ext ? SPACE_XRAM : SPACE_IRAM;
                res_addr = {XRAM_PAGE, ind_ptr};
            end
            MODE_IND16:
            begin
                res_space = SPACE_XRAM;
                res_addr = wide_data_pointer;
            end
            MODE_REG: res_addr = {8'h00, work_addr};
            MODE_IMM:
            begin
                res_space = SPACE_CODE;
                res_addr = program_counter_reg + {8'h00, opnd_req.field};
            end
            MODE_IDX_DATA:
            begin
                res_space = SPACE_CODE;
                res_addr = wide_data_pointer + arith16;
            end
            MODE_IDX_PROG:
            begin
                res_space = SPACE_CODE;
                res_addr = program_counter_reg + arith16;
            end
            default: res_space = SPACE_IRAM;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // The port write wins over a pipelined special-register write in the same cycle.
    wire op_sfr_we = state_reg == OP_ADDR && space_reg == SPACE_SFR && write_reg;
    wire sfr_we = sfr_wr || op_sfr_we;
    wire [7:0] sfr_wa = sfr_wr ? sfr_addr : mem_addr_reg[7:0];
    wire [7:0] sfr_wd = sfr_wr ? sfr_wdata : xram_wdata_reg;
    wire [8:0] port_look = sfr_lookup(sfr_addr, arch_reg);
    wire [8:0] op_look = sfr_lookup(mem_addr_reg[7:0], arch_reg);

    // Stack operations need the RAM port, so they are dropped while an operand
    // access owns it; the busy output tells the sequencer to hold them back.
    wire stack_op = alu_req.op == ALU_PUSH || alu_req.op == ALU_POP;
    wire alu_go = !sfr_we && !(stack_op && state_reg == OP_ADDR);
    wire push_go = alu_go && alu_req.op == ALU_PUSH;
    wire [7:0] stk_inc = stk + 8'h01;
    wire op_ram_we = state_reg == OP_ADDR && space_reg == SPACE_IRAM && write_reg;
    wire ram_we = push_go || op_ram_we;
    wire [7:0] ram_wa = push_go ? stk_inc : mem_addr_reg[7:0];
    wire [7:0] ram_wd = push_go ? alu_req.operand : xram_wdata_reg;

    wire cin = status[BIT_CARRY];
    wire [7:0] opv = alu_req.operand;
    wire [8:0] sum9 = {1'b0, arith} + {1'b0, opv} + {8'h00, cin && alu_req.op == ALU_ADDC};
    wire [4:0] sum5 = {1'b0, arith[3:0]} + {1'b0, opv[3:0]} + {4'h0, cin && alu_req.op == ALU_ADDC};
    wire [8:0] dif9 = {1'b0, arith} - {1'b0, opv} - {8'h00, cin};
    wire [4:0] dif5 = {1'b0, arith[3:0]} - {1'b0, opv[3:0]} - {4'h0, cin};
    wire [15:0] prod = {8'h00, arith} * {8'h00, second};
    wire div_zero = second == RST_ZERO;
    wire [7:0] quot = div_zero ? arith : arith / second;
    wire [7:0] remd = div_zero ? second : arith % second;

    always_comb
    begin
        arch_next = arch_reg;
        if (sfr_we)
        begin
            case (sfr_wa)
                ADDR_STACK: arch_next.stack_pointer = sfr_wd;
                ADDR_DP_LOW: arch_next.data_pointer_low = sfr_wd;
                ADDR_DP_HIGH: arch_next.data_pointer_high = sfr_wd;
                ADDR_STATUS: arch_next.program_status_word = sfr_wd;
                ADDR_ARITH: arch_next.main_arith_register = sfr_wd;
                ADDR_SECOND: arch_next.second_operand_reg = sfr_wd;
                default: arch_next = arch_reg;
            endcase
        end
        else if (alu_go)
        begin
            case (alu_req.op)
                ALU_ADD, ALU_ADDC:
                begin
                    arch_next.main_arith_register = sum9[7:0];
                    arch_next.program_status_word[BIT_CARRY] = sum9[8];
                    arch_next.program_status_word[BIT_HALF] = sum5[4];
                    arch_next.program_status_word[BIT_WRAP] = arith[7] == opv[7] && sum9[7] != arith[7];
                end
                ALU_SUBB:
                begin
                    arch_next.main_arith_register = dif9[7:0];
                    arch_next.program_status_word[BIT_CARRY] = dif9[8];
                    arch_next.program_status_word[BIT_HALF] = dif5[4];
                    arch_next.program_status_word[BIT_WRAP] = arith[7] != opv[7] && dif9[7] != arith[7];
                end
                ALU_MUL:
                begin
                    arch_next.main_arith_register = prod[7:0];
                    arch_next.second_operand_reg = prod[15:8];
                    arch_next.program_status_word[BIT_CARRY] = 1'b0;
                    arch_next.program_status_word[BIT_WRAP] = prod[15:8] != RST_ZERO;
                end
                ALU_DIV:
                begin
                    arch_next.main_arith_register = quot;
                    arch_next.second_operand_reg = remd;
                    arch_next.program_status_word[BIT_CARRY] = 1'b0;
                    arch_next.program_status_word[BIT_WRAP] = div_zero;
                end
                ALU_CLR_CARRY: arch_next.program_status_word[BIT_CARRY] = 1'b0;
                ALU_SET_CARRY: arch_next.program_status_word[BIT_CARRY] = 1'b1;
                ALU_CPL_CARRY: arch_next.program_status_word[BIT_CARRY] = !cin;
                ALU_AND_CARRY: arch_next.program_status_word[BIT_CARRY] = cin && alu_req.bit_in;
                ALU_OR_CARRY: arch_next.program_status_word[BIT_CARRY] = cin || alu_req.bit_in;
                ALU_MOV_CARRY: arch_next.program_status_word[BIT_CARRY] = alu_req.bit_in;
                ALU_PUSH: arch_next.stack_pointer = stk_inc;
                ALU_POP:
                begin
                    arch_next.main_arith_register = iram_reg[stk];
                    arch_next.stack_pointer = stk - 8'h01;
                end
                default: arch_next = arch_reg;
            endcase
        end
        // Parity is recomputed from the value being stored, so it can never lag.
        arch_next.program_status_word[BIT_PARITY] = ^arch_next.main_arith_register;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            arch_reg <= '{RST_STACK, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};
        end
        else
        begin
            arch_reg <= arch_next;
        end
    end

    // Data storage only; working banks sit in its lowest 32 bytes.
    always_ff @(posedge ref_clk)
    begin
        if (ram_we)
        begin
            iram_reg[ram_wa] <= ram_wd;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            sfr_rdata_reg <= RST_ZERO;
            sfr_hit_reg <= 1'b0;
        end
        else
        begin
            sfr_rdata_reg <= sfr_rd ? port_look[7:0] : RST_ZERO;
            sfr_hit_reg <= sfr_rd && port_look[8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Every operand access takes three cycles regardless of space, which keeps
    // the sequencer simple at the cost of a cycle on internal accesses.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_reg <= OP_IDLE;
            space_reg <= SPACE_IRAM;
            write_reg <= 1'b0;
            fault_reg <= 1'b0;
            mem_addr_reg <= START_ADDR;
            xram_wdata_reg <= RST_ZERO;
            code_re_reg <= 1'b0;
            xram_re_reg <= 1'b0;
            xram_we_reg <= 1'b0;
            opnd_busy_reg <= 1'b0;
            opnd_done_reg <= 1'b0;
            opnd_fault_reg <= 1'b0;
            opnd_rdata_reg <= RST_ZERO;
            hold_reg <= RST_ZERO;
        end
        else
        begin
            code_re_reg <= 1'b0;
            xram_re_reg <= 1'b0;
            xram_we_reg <= 1'b0;
            opnd_done_reg <= 1'b0;
            case (state_reg)
                OP_IDLE:
                begin
                    if (take)
                    begin
                        state_reg <= OP_ADDR;
                        space_reg <= res_space;
                        write_reg <= opnd_req.write && !res_fault;
                        fault_reg <= res_fault;
                        mem_addr_reg <= res_addr;
                        xram_wdata_reg <= opnd_req.wdata;
                        code_re_reg <= res_space == SPACE_CODE && !res_fault;
                        xram_re_reg <= res_space == SPACE_XRAM && !opnd_req.write;
                        xram_we_reg <= res_space == SPACE_XRAM && opnd_req.write;
                        opnd_busy_reg <= 1'b1;
                    end
                end
                OP_ADDR:
                begin
                    state_reg <= OP_DATA;
                    hold_reg <= space_reg == SPACE_SFR ? op_look[7:0] : iram_reg[mem_addr_reg[7:0]];
                end
                OP_DATA:
                begin
                    state_reg <= OP_IDLE;
                    opnd_busy_reg <= 1'b0;
                    opnd_done_reg <= 1'b1;
                    opnd_fault_reg <= fault_reg;
                    case (space_reg)
                        SPACE_CODE: opnd_rdata_reg <= fault_reg ? RST_ZERO : code_rdata;
                        SPACE_XRAM: opnd_rdata_reg <= xram_rdata;
                        default: opnd_rdata_reg <= hold_reg;
                    endcase
                end
                default: state_reg <= OP_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    wire [15:0] vec_addr = VEC_FIRST + ({11'h000, flow_req.irq_src} << VEC_SHIFT);
    wire [15:0] jump_addr = wide_data_pointer + arith16;
    wire [15:0] step_addr = program_counter_reg + {14'h0000, flow_req.len};
    wire [15:0] pc_next = flow_req.irq_take ? vec_addr :
                          flow_req.jump_idx ? jump_addr :
                          flow_req.step ? step_addr : program_counter_reg;
    wire [2:0] cyc_clip = instr_cycles < MIN_CYC ? MIN_CYC : instr_cycles;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            program_counter_reg <= START_ADDR;
            cnt_reg <= 3'h0;
            instr_done_reg <= 1'b0;
        end
        else
        begin
            program_counter_reg <= pc_next;
            if (instr_start)
            begin
                cnt_reg <= cyc_clip - MIN_CYC;
                instr_done_reg <= cyc_clip == MIN_CYC;
            end
            else
            begin
                cnt_reg <= cnt_reg == 3'h0 ? 3'h0 : cnt_reg - MIN_CYC;
                instr_done_reg <= cnt_reg == MIN_CYC;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    parity_track_a: assert property (arch_reg.program_status_word[BIT_PARITY] == ^arch_reg.main_arith_register)
        else $error("parity bit does not match main register");
    stack_reset_a: assert property ($fell(srst) |-> arch_reg.stack_pointer == RST_STACK && arith == RST_ZERO)
        else $error("wrong core register value after reset");
    start_addr_a: assert property ($fell(srst) |-> program_counter_reg == START_ADDR)
        else $error("fetch does not start at zero");
    push_inc_a: assert property (push_go |=> stk == $past(stk) + 8'h01 && iram_reg[stk] == $past(opv))
        else $error("push did not pre-increment stack pointer");
    bank_map_a: assert property (take && opnd_req.mode == MODE_REG |=>
        mem_addr_reg[7:0] == {3'h0, $past(bank), $past(opnd_req.field[2:0])})
        else $error("working register address outside selected bank");
    direct_high_a: assert property (take && opnd_req.mode == MODE_DIR && opnd_req.field > DIRECT_TOP |=>
        space_reg == SPACE_SFR)
        else $error("high direct address did not select special registers");
    index_addr_a: assert property (take && opnd_req.mode == MODE_IDX_DATA |=>
        mem_addr_reg == $past(wide_data_pointer) + $past(arith16) && code_re_reg == !$past(opnd_req.write))
        else $error("indexed address is not base plus main register");
    code_ro_a: assert property (take && opnd_req.write && res_space == SPACE_CODE |-> ##3 opnd_fault_reg && opnd_done_reg)
        else $error("program memory write was not faulted");
    access_time_a: assert property (take |-> ##1 opnd_busy_reg[*2] ##1 opnd_done_reg)
        else $error("operand access did not finish in three cycles");
    vector_a: assert property (flow_req.irq_take |=> program_counter_reg == VEC_FIRST + ($past({11'h000, flow_req.irq_src}) << VEC_SHIFT))
        else $error("interrupt vector address wrong");
    instr_len_a: assert property (instr_start && instr_cycles == MAX_CYC ##1 !instr_start[*6] |=>
        instr_done_reg && $past(!instr_done_reg, 1))
        else $error("seven cycle instruction did not end on time");
    carry_bool_a: assert property (alu_go && alu_req.op == ALU_AND_CARRY |=> status[BIT_CARRY] == ($past(cin) && $past(alu_req.bit_in)))
        else $error("carry bit accumulator wrong");

    push_cov: cover property (push_go ##1 alu_go && alu_req.op == ALU_POP);
    irq_cov: cover property (flow_req.irq_take ##1 flow_req.step);
    index_cov: cover property (take && opnd_req.mode == MODE_IDX_PROG ##3 opnd_done_reg);
    div_cov: cover property (alu_go && alu_req.op == ALU_DIV && div_zero);
endmodule
`default_nettype wire

// *** src/ccr_pkg.sv ***
`default_nettype none
package ccr_pkg;
    localparam logic [7:0] ADDR_STACK = 8'h81;
    localparam logic [7:0] ADDR_DP_LOW = 8'h82;
    localparam logic [7:0] ADDR_DP_HIGH = 8'h83;
    localparam logic [7:0] ADDR_STATUS = 8'hd0;
    localparam logic [7:0] ADDR_ARITH = 8'he0;
    localparam logic [7:0] ADDR_SECOND = 8'hf0;
    localparam logic [7:0] RST_STACK = 8'h07;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] DIRECT_TOP = 8'h7f;
    localparam logic [7:0] XRAM_PAGE = 8'h00;
    localparam int BIT_CARRY = 7;
    localparam int BIT_HALF = 6;
    localparam int BIT_UF0 = 5;
    localparam int BIT_BSH = 4;
    localparam int BIT_BSL = 3;
    localparam int BIT_WRAP = 2;
    localparam int BIT_UF1 = 1;
    localparam int BIT_PARITY = 0;
    localparam logic [15:0] START_ADDR = 16'h0000;
    localparam logic [15:0] VEC_FIRST = 16'h0003;
    localparam int VEC_SHIFT = 3;
    localparam logic [2:0] MIN_CYC = 3'h1;
    localparam logic [2:0] MAX_CYC = 3'h7;

    typedef enum logic [2:0] {MODE_DIR, MODE_IND8, MODE_IND16, MODE_REG, MODE_IMM,
                              MODE_IDX_DATA, MODE_IDX_PROG} ccr_mode_t;
    typedef enum logic [1:0] {SPACE_IRAM, SPACE_SFR, SPACE_XRAM, SPACE_CODE} ccr_space_t;
    typedef enum logic [3:0] {ALU_NONE, ALU_ADD, ALU_ADDC, ALU_SUBB, ALU_MUL, ALU_DIV,
                              ALU_CLR_CARRY, ALU_SET_CARRY, ALU_CPL_CARRY, ALU_AND_CARRY,
                              ALU_OR_CARRY, ALU_MOV_CARRY, ALU_PUSH, ALU_POP} ccr_alu_op_t;
    typedef enum logic [1:0] {OP_IDLE, OP_ADDR, OP_DATA} ccr_op_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic ext;
        ccr_mode_t mode;
        logic [7:0] field;
        logic [7:0] wdata;
    } ccr_opnd_req_t;

    typedef struct packed {
        ccr_alu_op_t op;
        logic [7:0] operand;
        logic bit_in;
    } ccr_alu_req_t;

    typedef struct packed {
        logic step;
        logic [1:0] len;
        logic irq_take;
        logic [4:0] irq_src;
        logic jump_idx;
    } ccr_flow_req_t;

    typedef struct packed {
        logic [7:0] stack_pointer;
        logic [7:0] data_pointer_low;
        logic [7:0] data_pointer_high;
        logic [7:0] program_status_word;
        logic [7:0] main_arith_register;
        logic [7:0] second_operand_reg;
    } ccr_regs_t;
endpackage
`default_nettype wire
